// ---- design/ivl_pkg.sv ----
// Constants and types for the index and vector load decoder
package ivl_pkg;
  // Prefix and width-override bytes
  localparam logic [7:0] PFX_X      = 8'hdd;
  localparam logic [7:0] PFX_Y      = 8'hfd;
  localparam logic [7:0] PFX_EXT    = 8'hed;
  localparam logic [7:0] SFX_S      = 8'h52;
  localparam logic [7:0] SFX_L      = 8'h49;
  localparam logic [7:0] SFX_SIS    = 8'h40;
  localparam logic [7:0] SFX_LIL    = 8'h5b;
  // Extended-page opcodes
  localparam logic [7:0] OP_VEC_FULL = 8'hc7;
  localparam logic [7:0] OP_VEC_LOW  = 8'h47;
  localparam logic [7:0] OP_PTR_X    = 8'h37;
  localparam logic [7:0] OP_PTR_Y    = 8'h31;
  // Index-page opcodes
  localparam logic [7:0] OP_LD_SAME  = 8'h37;
  localparam logic [7:0] OP_LD_OTHER = 8'h31;
  localparam logic [7:0] OP_ST_SAME  = 8'h3f;
  localparam logic [7:0] OP_ST_OTHER = 8'h3e;
  localparam logic [7:0] OP_IMM      = 8'h21;
  localparam logic [7:0] OP_ABS      = 8'h2a;
  localparam logic [7:0] OP_HH       = 8'h64;
  localparam logic [7:0] OP_HL       = 8'h65;
  localparam logic [7:0] OP_LH       = 8'h6c;
  localparam logic [7:0] OP_LL       = 8'h6d;
  localparam logic [7:0] OP_IMM_H    = 8'h26;
  localparam logic [7:0] OP_IMM_L    = 8'h2e;
  localparam logic [7:0] OP_H_A      = 8'h67;
  localparam logic [7:0] OP_H_B      = 8'h60;
  localparam logic [7:0] OP_H_C      = 8'h61;
  localparam logic [7:0] OP_H_D      = 8'h62;
  localparam logic [7:0] OP_H_E      = 8'h63;
  localparam logic [7:0] OP_L_A      = 8'h6f;
  localparam logic [7:0] OP_L_B      = 8'h68;
  localparam logic [7:0] OP_L_C      = 8'h69;
  localparam logic [7:0] OP_L_D      = 8'h6a;
  localparam logic [7:0] OP_L_E      = 8'h6b;
  // Widths and counts
  localparam int         ADDR_W     = 24;
  localparam logic [7:0] ZERO_PAGE  = 8'h00;
  localparam logic [1:0] LAST_SHORT = 2'h1;
  localparam logic [1:0] LAST_LONG  = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_IMM, ST_DISP, ST_MEMRD, ST_MEMWR} ivl_state_e;
  typedef enum logic [1:0] {PF_NONE, PF_X, PF_Y, PF_EXT} ivl_pfx_e;
  typedef enum logic [1:0] {DO_IMM, DO_ABS, DO_LOAD, DO_STORE} ivl_op_e;
endpackage

// ---- design/ivl_decoder.sv ----
// Index and vector load decoder with byte-wide memory sequencer
// Summary of operation
// RL1 - ED C7 copies pointer pair into vector
// RL2 - ED 47 copies accumulator to vector low
// RL3 - DD/FD 64,65,6C,6D copy index halves
// RL4 - DD/FD 26/2E load immediate into half
// RL5 - 67,60-63 load high half from A-E
// RL6 - 6F,68-6B load low half from A-E
// RL7 - ED 37/31 load index from pointer pair
// RL8 - 52/49 override data width, cycles follow
// RL9 - DD/FD 37/31 dd load same/other index
// RL10 - Displacement transfers take five to seven cycles
// RL11 - DD/FD 21 load immediate, low byte first
// RL12 - DD/FD 2A load index from absolute address
// RL13 - 5B/40 force long or short address
// RL14 - Mixed widths use base or zero upper
// RL15 - DD/FD 3F/3E dd store same/other index
// RL16 - Displacement sign-extended, wraps at active width
// RL17 - Two or three bytes, low byte first
`timescale 1ns/1ps
module ivl_decoder
  import ivl_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // Instruction control
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] start_pc,
  input  wire logic              long_address_mode,
  output logic                   busy,
  output logic                   done,
  output logic                   illegal,
  // Core registers read
  input  wire logic [7:0]        acc,
  input  wire logic [7:0]        reg_b,
  input  wire logic [7:0]        reg_c,
  input  wire logic [7:0]        reg_d,
  input  wire logic [7:0]        reg_e,
  input  wire logic [ADDR_W-1:0] pointer_pair,
  input  wire logic [7:0]        upper_address_base,
  // Registers written
  output logic [ADDR_W-1:0]      index_reg_x,
  output logic [ADDR_W-1:0]      index_reg_y,
  output logic [15:0]            int_vector,
  // Memory port
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_rd,
  output logic                   mem_we,
  output logic [7:0]             mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic [7:0]        mem_rdata_next
);

  ivl_state_e        state;
  ivl_pfx_e          pfx;
  ivl_op_e           op;
  logic              tgt_y;
  logic              base_y;
  logic              dlong;
  logic              ilong;
  logic              sfx_seen;
  logic [1:0]        cnt;
  logic [ADDR_W-1:0] imm;
  logic [ADDR_W-1:0] rbuf;
  logic              last;
  logic              bad;
  logic              hw_en;
  logic              hw_hi;
  logic [7:0]        hw_val;
  logic              fw_en;
  logic              fw_long;
  logic [ADDR_W-1:0] fw_val;
  logic              sel_y;
  logic [ADDR_W-1:0] cur;
  logic [ADDR_W-1:0] src;
  logic [7:0]        b;

  function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a,
                                                  input logic lng);
    return lng ? a + 24'h1 : {a[23:16], a[15:0] + 16'h1};
  endfunction

  function automatic logic [ADDR_W-1:0] mode_addr(input logic [ADDR_W-1:0] a,
                                                  input logic lng, input logic [7:0] hi);
    return lng ? a : {hi, a[15:0]};
  endfunction

  function automatic logic [ADDR_W-1:0] disp_add(input logic [ADDR_W-1:0] base,
                                                 input logic [7:0] d, input logic lng,
                                                 input logic [7:0] hi);
    logic [ADDR_W-1:0] s;
    s = base + {{16{d[7]}}, d};
    return mode_addr(s, lng, hi);
  endfunction

  function automatic logic [ADDR_W-1:0] set_byte(input logic [ADDR_W-1:0] v,
                                                 input logic [1:0] i, input logic [7:0] d);
    logic [ADDR_W-1:0] r;
    r = v;
    case (i)
      2'h0:    r[7:0]   = d;
      2'h1:    r[15:8]  = d;
      default: r[23:16] = d;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] get_byte(input logic [ADDR_W-1:0] v, input logic [1:0] i);
    case (i)
      2'h0:    return v[7:0];
      2'h1:    return v[15:8];
      default: return v[23:16];
    endcase
  endfunction

  function automatic logic [1:0] last_idx(input logic lng);
    return lng ? LAST_LONG : LAST_SHORT;
  endfunction

  assign b      = mem_rdata;
  assign sel_y  = (pfx == PF_Y);
  assign cur    = sel_y ? index_reg_y : index_reg_x;
  assign src    = tgt_y ? index_reg_y : index_reg_x;
  assign busy   = (state != ST_IDLE);
  assign mem_rd = busy && (state != ST_MEMWR);
  assign mem_we = (state == ST_MEMWR);

  // Half-register decode
  always_comb begin
    hw_en  = 1'b0;
    hw_hi  = 1'b0;
    hw_val = 8'h00;
    if (state == ST_FETCH && (pfx == PF_X || pfx == PF_Y)) begin
      hw_en = 1'b1;
      case (b)
        OP_HH:    begin hw_hi = 1'b1; hw_val = cur[15:8]; end // see RL3
        OP_HL:    begin hw_hi = 1'b1; hw_val = cur[7:0]; end
        OP_LH:    hw_val = cur[15:8];
        OP_LL:    hw_val = cur[7:0];
        OP_IMM_H: begin hw_hi = 1'b1; hw_val = mem_rdata_next; end // see RL4
        OP_IMM_L: hw_val = mem_rdata_next;
        OP_H_A:   begin hw_hi = 1'b1; hw_val = acc; end // see RL5
        OP_H_B:   begin hw_hi = 1'b1; hw_val = reg_b; end
        OP_H_C:   begin hw_hi = 1'b1; hw_val = reg_c; end
        OP_H_D:   begin hw_hi = 1'b1; hw_val = reg_d; end
        OP_H_E:   begin hw_hi = 1'b1; hw_val = reg_e; end
        OP_L_A:   hw_val = acc; // see RL6
        OP_L_B:   hw_val = reg_b;
        OP_L_C:   hw_val = reg_c;
        OP_L_D:   hw_val = reg_d;
        OP_L_E:   hw_val = reg_e;
        default:  hw_en = 1'b0;
      endcase
    end
  end

  // Instruction end and illegal decode
  always_comb begin
    last = 1'b0;
    bad  = 1'b0;
    unique case (state)
      ST_FETCH: begin
        unique case (pfx)
          PF_NONE: bad = !((!sfx_seen && (b == SFX_S || b == SFX_SIS || b == SFX_L ||
                                           b == SFX_LIL)) ||
                           b == PFX_X || b == PFX_Y || b == PFX_EXT);
          PF_EXT:  bad = !(b == OP_VEC_FULL || b == OP_VEC_LOW || b == OP_PTR_X ||
                           b == OP_PTR_Y);
          PF_X, PF_Y: bad = !(hw_en || b == OP_LD_SAME || b == OP_LD_OTHER ||
                              b == OP_ST_SAME || b == OP_ST_OTHER || b == OP_IMM ||
                              b == OP_ABS);
        endcase
        last = bad || hw_en || (pfx == PF_EXT && (b == OP_VEC_FULL || b == OP_VEC_LOW));
      end
      ST_IMM:   last = (op == DO_IMM) && (cnt == last_idx(ilong));
      ST_MEMRD, ST_MEMWR: last = (cnt == last_idx(dlong)); // see RL17
      default:  last = 1'b0;
    endcase
  end

  // Whole index register writes
  always_comb begin
    fw_en   = 1'b0;
    fw_long = dlong;
    fw_val  = set_byte(rbuf, cnt, b); // see RL17
    if (state == ST_IMM && last) begin
      fw_en   = 1'b1;
      fw_long = ilong;
      fw_val  = set_byte(imm, cnt, b); // see RL11
    end else if (state == ST_MEMRD && last && (op == DO_LOAD || op == DO_ABS)) begin // see RL12
      fw_en = 1'b1;
    end
  end

  // Completion strobes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      done    <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done    <= last;
      illegal <= bad;
    end
  end

  // Vector register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      int_vector <= 16'h0000;
    end else if (state == ST_FETCH && pfx == PF_EXT) begin
      if (b == OP_VEC_FULL) int_vector <= pointer_pair[15:0]; // see RL1
      if (b == OP_VEC_LOW) int_vector[7:0] <= acc; // see RL2
    end
  end

  // Index registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      index_reg_x <= 24'h000000;
      index_reg_y <= 24'h000000;
    end else if (hw_en) begin
      if (sel_y && hw_hi) index_reg_y[15:8] <= hw_val;
      if (sel_y && !hw_hi) index_reg_y[7:0] <= hw_val;
      if (!sel_y && hw_hi) index_reg_x[15:8] <= hw_val;
      if (!sel_y && !hw_hi) index_reg_x[7:0] <= hw_val;
    end else if (fw_en) begin
      if (tgt_y) index_reg_y <= fw_long ? fw_val : {index_reg_y[23:16], fw_val[15:0]};
      else index_reg_x <= fw_long ? fw_val : {index_reg_x[23:16], fw_val[15:0]};
    end
  end

  // Sequencer and memory port
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state     <= ST_IDLE;
      pfx       <= PF_NONE;
      op        <= DO_IMM;
      tgt_y     <= 1'b0;
      base_y    <= 1'b0;
      dlong     <= 1'b0;
      ilong     <= 1'b0;
      sfx_seen  <= 1'b0;
      cnt       <= 2'h0;
      imm       <= 24'h000000;
      rbuf      <= 24'h000000;
      mem_addr  <= 24'h000000;
      mem_wdata <= 8'h00;
    end else if (last) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (start) begin
          state    <= ST_FETCH;
          mem_addr <= start_pc;
          pfx      <= PF_NONE;
          sfx_seen <= 1'b0;
          dlong    <= long_address_mode;
          ilong    <= long_address_mode;
          cnt      <= 2'h0;
          imm      <= 24'h000000;
          rbuf     <= 24'h000000;
        end
        ST_FETCH: begin
          mem_addr <= addr_step(mem_addr, long_address_mode);
          unique case (pfx)
            PF_NONE: begin
              sfx_seen <= 1'b1;
              if (b == SFX_S || b == SFX_SIS) begin // see RL8
                dlong <= 1'b0;
                ilong <= 1'b0; // see RL13
              end
              if (b == SFX_L || b == SFX_LIL) begin // see RL8
                dlong <= 1'b1;
                ilong <= 1'b1; // see RL13
              end
              if (b == PFX_X) pfx <= PF_X;
              if (b == PFX_Y) pfx <= PF_Y;
              if (b == PFX_EXT) pfx <= PF_EXT;
            end
            PF_EXT: begin
              op       <= DO_LOAD;
              tgt_y    <= (b == OP_PTR_Y);
              state    <= ST_MEMRD;
              mem_addr <= mode_addr(pointer_pair, dlong, upper_address_base); // see RL7
            end
            default: begin
              base_y <= sel_y; // see RL9
              tgt_y  <= sel_y ^ (b == OP_LD_OTHER || b == OP_ST_OTHER); // see RL9, RL15
              if (b == OP_IMM || b == OP_ABS) state <= ST_IMM;
              else state <= ST_DISP;
              if (b == OP_IMM) op <= DO_IMM;
              else if (b == OP_ABS) op <= DO_ABS; // see RL12
              else if (b == OP_ST_SAME || b == OP_ST_OTHER) op <= DO_STORE;
              else op <= DO_LOAD;
            end
          endcase
        end
        ST_IMM: begin
          imm      <= set_byte(imm, cnt, b);
          cnt      <= cnt + 2'h1;
          mem_addr <= addr_step(mem_addr, long_address_mode);
          if (cnt == last_idx(ilong)) begin
            state <= ST_MEMRD;
            cnt   <= 2'h0;
            if (!ilong && dlong) mem_addr <= {ZERO_PAGE, b, imm[7:0]}; // see RL14
            else mem_addr <= mode_addr(set_byte(imm, cnt, b), ilong && dlong,
                                       upper_address_base); // see RL12, RL14
          end
        end
        ST_DISP: begin
          cnt      <= 2'h0;
          mem_addr <= disp_add(base_y ? index_reg_y : index_reg_x, b, dlong,
                               upper_address_base); // see RL16
          if (op == DO_STORE) begin
            state     <= ST_MEMWR; // see RL15
            mem_wdata <= src[7:0];
          end else begin
            state <= ST_MEMRD; // see RL10
          end
        end
        ST_MEMRD: begin
          rbuf     <= set_byte(rbuf, cnt, b);
          cnt      <= cnt + 2'h1;
          mem_addr <= addr_step(mem_addr, dlong);
        end
        ST_MEMWR: begin
          cnt       <= cnt + 2'h1;
          mem_addr  <= addr_step(mem_addr, dlong);
          mem_wdata <= get_byte(src, cnt + 2'h1); // see RL17
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  vec_full_a: assert property (state == ST_FETCH && pfx == PF_EXT && b == OP_VEC_FULL
    |=> done && int_vector == $past(pointer_pair[15:0])) else $error("vector full load"); // see RL1
  vec_low_a: assert property (state == ST_FETCH && pfx == PF_EXT && b == OP_VEC_LOW
    |=> done && int_vector[7:0] == $past(acc) && int_vector[15:8] == $past(int_vector[15:8]))
    else $error("vector low load"); // see RL2
  half_copy_a: assert property (state == ST_FETCH && pfx == PF_X && b == OP_HL
    |=> index_reg_x[15:8] == $past(index_reg_x[7:0])) else $error("half copy"); // see RL3
  half_imm_a: assert property (state == ST_FETCH && pfx == PF_Y && b == OP_IMM_L
    |=> done && index_reg_y[7:0] == $past(mem_rdata_next)) else $error("half imm"); // see RL4
  high_src_a: assert property (state == ST_FETCH && pfx == PF_X && b == OP_H_B
    |=> index_reg_x[15:8] == $past(reg_b)) else $error("high from reg"); // see RL5
  low_src_a: assert property (state == ST_FETCH && pfx == PF_Y && b == OP_L_A
    |=> index_reg_y[7:0] == $past(acc)) else $error("low from reg"); // see RL6
  ptr_short_a: assert property (state == ST_FETCH && pfx == PF_EXT && b == OP_PTR_X && !dlong
    |=> mem_rd && mem_addr == {upper_address_base, pointer_pair[15:0]} ##2 done)
    else $error("pointer load short"); // see RL7
  ptr_long_a: assert property (state == ST_FETCH && pfx == PF_EXT && b == OP_PTR_Y && dlong
    |-> ##4 done) else $error("pointer load long"); // see RL8
  disp_time_a: assert property (state == ST_DISP && dlong |-> !done [*4] ##1 done)
    else $error("disp long timing"); // see RL10
  imm_time_a: assert property (state == ST_FETCH && pfx == PF_X && b == OP_IMM && !ilong
    |-> ##3 done) else $error("imm short timing"); // see RL11
  abs_time_a: assert property (state == ST_FETCH && pfx == PF_Y && b == OP_ABS && ilong && dlong
    |-> ##7 done) else $error("abs long timing"); // see RL12
  disp_addr_a: assert property (state == ST_DISP && dlong
    |=> mem_addr == $past(base_y ? index_reg_y : index_reg_x) + {{16{$past(b[7])}}, $past(b)})
    else $error("disp address"); // see RL16

endmodule // ivl_decoder

// ---- sim/ivl_mem_model.sv ----
// Byte memory model standing on the far side of the decoder
`timescale 1ns/1ps
module ivl_mem_model
  import ivl_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Memory access
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_rd,
  input  wire logic              mem_we,
  input  wire logic [7:0]        mem_wdata,
  output logic [7:0]             mem_rdata,
  output logic [7:0]             mem_rdata_next
);
  logic [7:0]        mem [0:65535];
  logic [31:0]       wr_q [$];
  logic [ADDR_W-1:0] nxt;
  logic [7:0]        v0, v1;

  // Content is keyed by the full address, so a wrong top byte reads wrong data
  assign nxt = mem_addr + 24'h1;
  assign v0 = mem[mem_addr[15:0]] ^ mem_addr[23:16];
  assign v1 = mem[nxt[15:0]] ^ nxt[23:16];
  // Outside a read the lines do not keep the byte
  assign mem_rdata = mem_rd ? v0 : ~v0;
  assign mem_rdata_next = mem_rd ? v1 : ~v1;

  // Store bytes and log every write in order
  always @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_addr[15:0]] <= mem_wdata ^ mem_addr[23:16];
      wr_q.push_back({mem_addr, mem_wdata});
    end
  end
endmodule // ivl_mem_model

// ---- sim/tb.sv ----
// Self-checking bench for the index and vector load decoder
`timescale 1ns/1ps
module tb
  import ivl_pkg::*;
;
  logic        sys_clk = 1'b0, srst = 1'b1, start = 1'b0, long_address_mode = 1'b0;
  logic        busy, done, illegal, mem_rd, mem_we;
  logic [23:0] start_pc = 24'h0, pointer_pair = 24'h0, index_reg_x, index_reg_y, mem_addr;
  logic [7:0]  acc = 8'h0, reg_b = 8'h0, reg_c = 8'h0, reg_d = 8'h0, reg_e = 8'h0;
  logic [7:0]  upper_address_base = 8'h0, mem_wdata, mem_rdata, mem_rdata_next;
  logic [15:0] int_vector, ev;
  logic [23:0] ex, ey;
  logic [31:0] ew [$];
  logic [7:0]  mops [4] = '{OP_LD_SAME, OP_LD_OTHER, OP_ST_SAME, OP_ST_OTHER};
  logic [7:0]  hops [16] = '{OP_HH, OP_HL, OP_LH, OP_LL, OP_IMM_H, OP_IMM_L, OP_H_A, OP_H_B,
                             OP_H_C, OP_H_D, OP_H_E, OP_L_A, OP_L_B, OP_L_C, OP_L_D, OP_L_E};
  int          n_fail = 0, compares = 0;

  always #10 sys_clk = ~sys_clk;

  ivl_decoder dut (.sys_clk, .srst, .start, .start_pc, .long_address_mode, .busy, .done,
    .illegal, .acc, .reg_b, .reg_c, .reg_d, .reg_e, .pointer_pair, .upper_address_base,
    .index_reg_x, .index_reg_y, .int_vector, .mem_addr, .mem_rd, .mem_we, .mem_wdata,
    .mem_rdata, .mem_rdata_next);
  ivl_mem_model mem_i (.sys_clk, .mem_addr, .mem_rd, .mem_we, .mem_wdata, .mem_rdata,
    .mem_rdata_next);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic put(input logic [23:0] a, input logic [7:0] b);
    mem_i.mem[a[15:0]] = b ^ a[23:16];
  endtask

  function automatic logic [7:0] rd8(input logic [23:0] a);
    return mem_i.mem[a[15:0]] ^ a[23:16];
  endfunction

  // Data addresses wrap within the low 16 bits at short width
  function automatic logic [23:0] adv(input logic [23:0] a, input int i, input logic l);
    return l ? a + 24'(i) : {a[23:16], a[15:0] + 16'(i)};
  endfunction

  function automatic logic [23:0] rdw(input logic [23:0] a, input logic l);
    return {l ? rd8(adv(a, 2, l)) : 8'h00, rd8(adv(a, 1, l)), rd8(a)};
  endfunction

  // Short width keeps the upper byte of the target
  function automatic logic [23:0] mrg(input logic [23:0] o, input logic [23:0] w, input logic l);
    return l ? w : {o[23:16], w[15:0]};
  endfunction

  function automatic logic [23:0] sa(input logic [23:0] a, input logic l);
    return l ? a : {upper_address_base, a[15:0]};
  endfunction

  // Runs one instruction against the reference model
  task automatic exec(input logic [7:0] sfx, input logic [7:0] p, input logic [7:0] op,
                      input int n);
    logic [7:0]  b [6];
    logic [7:0]  src [5];
    logic [23:0] bi, ot, a, d;
    logic        l;
    int          k;
    @(posedge sys_clk);
    {acc, reg_b, reg_c, reg_d} <= $urandom;
    {reg_e, upper_address_base} <= 16'($urandom);
    pointer_pair <= 24'($urandom);
    start_pc <= {8'($urandom), 16'hf000};
    start <= 1'b1;
    #1;
    b = '{sfx, p, op, 8'($urandom), 8'($urandom), 8'($urandom)};
    k = (sfx == 8'h00) ? 1 : 0;
    for (int i = k; i < 6; i++) put(start_pc + 24'(i - k), b[i]);
    l = (sfx == SFX_S || sfx == SFX_SIS) ? 1'b0 :
        (sfx == SFX_L || sfx == SFX_LIL) ? 1'b1 : long_address_mode;
    src = '{acc, reg_b, reg_c, reg_d, reg_e};
    bi = (p == PFX_X) ? ex : ey;
    ot = (p == PFX_X) ? ey : ex;
    d = {{16{b[3][7]}}, b[3]};
    a = l ? bi + d : {upper_address_base, bi[15:0] + d[15:0]};
    if (p == PFX_EXT) begin
      if (op == OP_VEC_FULL) ev = pointer_pair[15:0];
      else if (op == OP_VEC_LOW) ev[7:0] = acc;
      else if (op == OP_PTR_X) ex = mrg(ex, rdw(sa(pointer_pair, l), l), l);
      else ey = mrg(ey, rdw(sa(pointer_pair, l), l), l);
    end else begin
      case (op)
        OP_LD_SAME:  bi = mrg(bi, rdw(a, l), l);
        OP_LD_OTHER: ot = mrg(ot, rdw(a, l), l);
        OP_IMM:      bi = mrg(bi, {b[5], b[4], b[3]}, l);
        OP_ABS:      bi = mrg(bi, rdw(sa({b[5], b[4], b[3]}, l), l), l);
        OP_HH, OP_LL: ;
        OP_HL:       bi[15:8] = bi[7:0];
        OP_LH:       bi[7:0] = bi[15:8];
        OP_IMM_H:    bi[15:8] = b[3];
        OP_IMM_L:    bi[7:0] = b[3];
        OP_ST_SAME, OP_ST_OTHER:
          for (int i = 0; i < (l ? 3 : 2); i++)
            ew.push_back({adv(a, i, l), 8'(((op == OP_ST_SAME) ? bi : ot) >> (8 * i))});
        default: begin
          if (op[7:4] == 4'h6) begin
            k = (op[2:0] == 3'h7) ? 0 : int'(op[2:0]) + 1;
            if (op[3]) bi[7:0] = src[k];
            else bi[15:8] = src[k];
          end
        end
      endcase
      if (p == PFX_X) begin
        ex = bi;
        ey = ot;
      end else begin
        ey = bi;
        ex = ot;
      end
    end
    @(posedge sys_clk);
    start <= 1'b0;
    for (k = 1; k < 20; k++) begin
      @(posedge sys_clk);
      #1;
      if (done === 1'b1) break;
      chk("busy", 1, busy);
    end
    chk("cycles", n, k);
    chk("illegal", op == 8'h00, illegal);
    chk("busy_at_done", 0, busy);
    chk("index_x", ex, index_reg_x);
    chk("index_y", ey, index_reg_y);
    chk("vector", ev, int_vector);
    chk("write_count", ew.size(), mem_i.wr_q.size());
    foreach (ew[i]) if (i < mem_i.wr_q.size()) chk("write", ew[i], mem_i.wr_q[i]);
    ew.delete();
    mem_i.wr_q.delete();
    @(posedge sys_clk);
    #1;
    chk("done_pulse", 0, done);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    logic [7:0] p;
    void'($urandom(32'hce1da8b0));
    for (int i = 0; i < 65536; i++) mem_i.mem[i] = 8'($urandom);
    ex = 24'h0;
    ey = 24'h0;
    ev = 16'h0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk("reset_busy", 0, busy);
    chk("reset_x", 0, index_reg_x);
    chk("reset_y", 0, index_reg_y);
    chk("reset_vector", 0, int_vector);
    // Only override bytes opposite to the current address mode are issued
    for (int r = 0; r < 6; r++) begin
      @(posedge sys_clk);
      long_address_mode <= r[0];
      for (int j = 0; j < 2; j++) begin
        p = j ? PFX_Y : PFX_X;
        exec(8'h00, p, OP_IMM, r[0] ? 5 : 4);
        exec(r[0] ? SFX_SIS : SFX_LIL, p, OP_IMM, r[0] ? 5 : 6);
        exec(8'h00, p, OP_ABS, r[0] ? 8 : 6);
        exec(r[0] ? SFX_SIS : SFX_LIL, p, OP_ABS, r[0] ? 7 : 9);
        foreach (mops[i]) begin
          exec(8'h00, p, mops[i], r[0] ? 6 : 5);
          exec(r[0] ? SFX_S : SFX_L, p, mops[i], r[0] ? 6 : 7);
        end
        foreach (hops[i]) exec(8'h00, p, hops[i], 2);
        exec(8'h00, PFX_EXT, j ? OP_PTR_Y : OP_PTR_X, r[0] ? 5 : 4);
        exec(r[0] ? SFX_S : SFX_L, PFX_EXT, j ? OP_PTR_Y : OP_PTR_X, r[0] ? 5 : 6);
      end
      exec(8'h00, PFX_EXT, OP_VEC_FULL, 2);
      exec(8'h00, PFX_EXT, OP_VEC_LOW, 2);
      exec(8'h00, PFX_X, 8'h00, 2);
    end
    stop_test();
  end
endmodule // tb
